//--- core/cdr_pkg.sv
package cdr_pkg;

  // ------------------------------------------------------------
  // Serial word layout
  // ------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int NUM_SLOTS = 7;

  // Register addresses carried in the low nibble
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam logic [3:0] ADDR_FMT_LOW = 4'h1;
  localparam logic [3:0] ADDR_FMT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_DLY_SYNC = 4'h3;
  localparam logic [3:0] ADDR_DDLY = 4'h4;
  localparam logic [3:0] ADDR_DIVIDER = 4'h5;
  localparam logic [3:0] ADDR_PROTECT = 4'hF;

  // Storage slot of the global, digital delay, divider and protect registers
  localparam logic [2:0] SLOT_GLOBAL = 3'h0;
  localparam logic [2:0] SLOT_DDLY = 3'h4;
  localparam logic [2:0] SLOT_DIVIDER = 3'h5;
  localparam logic [2:0] SLOT_PROTECT = 3'h6;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 4;
  localparam int POWER_DOWN_BIT = 5;
  localparam int GROUP_SLEEP_LSB = 6;
  localparam int IN_BUF_LSB = 10;
  localparam int IN0_DIV_LSB = 14;
  localparam int IN0_MUX_LSB = 17;
  localparam int IN1_DIV_LSB = 19;
  localparam int IN1_MUX_LSB = 22;
  localparam int FMT3_LSB = 4;
  localparam int FMT3_W = 3;
  localparam int FMT4_LOW_LSB = 16;
  localparam int FMT4_HIGH_LSB = 4;
  localparam int FMT4_W = 4;
  localparam int ADLY_LSB = 4;
  localparam int HALF_SHIFT_BIT = 10;
  localparam int QUAL_LSB = 11;
  localparam int POL0_BIT = 14;
  localparam int POL1_BIT = 15;
  localparam int EXCLUDE_LSB = 16;
  localparam int OFFSET_LSB = 20;
  localparam int FAST_LSB = 23;
  localparam int AUTO0_BIT = 25;
  localparam int AUTO1_BIT = 26;
  localparam int DDLY_LSB = 4;
  localparam int DIV_A_LOW_LSB = 4;
  localparam int DIV_A_HIGH_LSB = 7;
  localparam int DIV_B_MAIN_LSB = 10;
  localparam int SEL12_BIT = 13;
  localparam int SEL13_BIT = 14;
  localparam int DIV_B_DLY_LSB = 17;
  localparam int LOCK_BIT = 4;

  // ------------------------------------------------------------
  // Writable masks and silicon defaults, per slot
  // ------------------------------------------------------------
  localparam logic [NUM_SLOTS-1:0][31:0] REG_MASK = {
    32'h0000_0010, 32'h0FFE_7FF0, 32'h0000_3FF0, 32'h07FF_DFF0,
    32'h0FFF_FFF0, 32'hFFFF_FFF0, 32'h00FF_CFF0};
  localparam logic [NUM_SLOTS-1:0][31:0] REG_DEFAULT = {
    32'h0000_0000, 32'h0002_0490, 32'h0000_0050, 32'h0630_C000,
    32'h0111_1110, 32'h1111_2490, 32'h0010_8000};

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [27:0] data;
    logic [3:0] addr;
  } cdr_word_type;

  typedef struct packed {
    logic power_down;
    logic [3:0] group_sleep_bit;
    logic [1:0] in_buf_type;
    logic [2:0] in0_div;
    logic [1:0] in0_mux;
    logic [2:0] in1_div;
    logic [1:0] in1_mux;
    logic [5:0] analog_delay_value;
    logic half_shift_bit;
    logic [1:0] sync_qualify_field;
    logic sync_in0_polarity;
    logic sync_in1_polarity;
    logic exclude_group_a_low;
    logic exclude_group_a_high;
    logic exclude_group_b_main;
    logic exclude_group_b_delayed;
    logic offset_off_group_a_low;
    logic offset_off_group_a_high;
    logic offset_off_group_b_main;
    logic sync_in0_fast_enable;
    logic sync_in1_fast_enable;
    logic sync_in0_auto_trigger;
    logic sync_in1_auto_trigger;
    logic [9:0] digital_delay_count;
    logic [2:0] divider_group_a_low;
    logic [2:0] divider_group_a_high;
    logic [2:0] divider_group_b_main;
    logic delay_select_out12;
    logic delay_select_out13;
    logic [10:0] divider_group_b_delayed;
    logic register_write_lock;
  } cdr_config_type;

endpackage

//--- core/cdr_serial_rx.sv
`timescale 1ns/10ps
module cdr_serial_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  output cdr_pkg::cdr_word_type word,
  output logic word_valid
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Clock and data see equal latency, so setup at the pins is kept
  logic [1:0] clk_s_r;
  logic [1:0] data_s_r;
  logic [1:0] le_s_r;
  logic clk_d_r;
  logic le_d_r;
  logic [31:0] shift_r;
  cdr_pkg::cdr_word_type word_r;
  logic valid_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_s_r <= 2'h0;
      data_s_r <= 2'h0;
      le_s_r <= 2'h0;
      clk_d_r <= 1'b0;
      le_d_r <= 1'b0;
    end
    else
    begin
      clk_s_r <= {clk_s_r[0], ser_clk};
      data_s_r <= {data_s_r[0], ser_data};
      le_s_r <= {le_s_r[0], ser_le};
      clk_d_r <= clk_s_r[1];
      le_d_r <= le_s_r[1];
    end
  end

  // ------------------------------------------------------------
  // Shift register, MSB first
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= 32'h0000_0000;
    else if (clk_s_r[1] && !clk_d_r)
      shift_r <= {shift_r[30:0], data_s_r[1]};
  end

  // Word applied on the strobe's rising edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_r <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= le_s_r[1] && !le_d_r;
      if (le_s_r[1] && !le_d_r)
        word_r <= shift_r;
    end
  end

  assign word = word_r;
  assign word_valid = valid_r;

endmodule // cdr_serial_rx

//--- core/cdr_regbank.sv
`timescale 1ns/10ps
module cdr_regbank (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA,
  input wire logic LATCH_ENABLE_STROBE,
  output cdr_pkg::cdr_config_type CFG,
  output logic [13:0][3:0] OUTPUT_FORMAT_FIELD,
  output logic [3:0] GROUP_ACTIVE,
  output logic DEVICE_POWER_DOWN,
  output logic ANALOG_DELAY_ACTIVE,
  output logic SYNC_START_IN0,
  output logic SYNC_START_IN1,
  output logic [3:0] SYNC_GROUPS,
  output logic SOFT_RESET_FLAG,
  output logic WRITE_LOCKED,
  output logic WRITE_REJECTED
);

  // ------------------------------------------------------------
  // Serial receiver
  // ------------------------------------------------------------
  cdr_pkg::cdr_word_type rx_word;
  logic rx_valid;
  logic [31:0] rx_full;

  cdr_serial_rx u_rx (
    .clk(CLK),
    .rst_n(RST_N),
    .ser_clk(SERIAL_CLOCK),
    .ser_data(SERIAL_DATA),
    .ser_le(LATCH_ENABLE_STROBE),
    .word(rx_word),
    .word_valid(rx_valid)
  );

  assign rx_full = rx_word;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [2:0] slot;
  logic slot_hit;
  logic lock_blocks;
  logic accept;
  logic soft_reset_hit;
  logic [31:0] reg_r [cdr_pkg::NUM_SLOTS];

  always_comb
  begin
    slot = 3'h0;
    slot_hit = 1'b1;
    case (rx_word.addr)
      cdr_pkg::ADDR_GLOBAL: slot = 3'h0;
      cdr_pkg::ADDR_FMT_LOW: slot = 3'h1;
      cdr_pkg::ADDR_FMT_HIGH: slot = 3'h2;
      cdr_pkg::ADDR_DLY_SYNC: slot = 3'h3;
      cdr_pkg::ADDR_DDLY: slot = cdr_pkg::SLOT_DDLY;
      cdr_pkg::ADDR_DIVIDER: slot = cdr_pkg::SLOT_DIVIDER;
      cdr_pkg::ADDR_PROTECT: slot = cdr_pkg::SLOT_PROTECT;
      default: slot_hit = 1'b0;
    endcase
  end

  // Lock register itself stays writable, else the lock could never be lifted
  assign lock_blocks = reg_r[cdr_pkg::SLOT_PROTECT][cdr_pkg::LOCK_BIT]
    && (slot != cdr_pkg::SLOT_PROTECT);
  assign accept = rx_valid && slot_hit && !lock_blocks;
  assign soft_reset_hit = accept && (slot == cdr_pkg::SLOT_GLOBAL)
    && rx_full[cdr_pkg::SOFT_RESET_BIT];

  // ------------------------------------------------------------
  // Global register
  // ------------------------------------------------------------
  // Soft-reset bit stays set until the next accepted write to another register
  // clears it; a global write loads its own value and resets again only if it sets the bit.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      reg_r[0] <= cdr_pkg::REG_DEFAULT[0];
    else if (soft_reset_hit)
    begin
      reg_r[0] <= cdr_pkg::REG_DEFAULT[0];
      reg_r[0][cdr_pkg::SOFT_RESET_BIT] <= 1'b1;
    end
    else if (accept && (slot == cdr_pkg::SLOT_GLOBAL))
      reg_r[0] <= rx_full & cdr_pkg::REG_MASK[0];
    else if (accept)
      reg_r[0][cdr_pkg::SOFT_RESET_BIT] <= 1'b0;
  end

  // ------------------------------------------------------------
  // Remaining registers
  // ------------------------------------------------------------
  // Power-down never touches these, so settings survive it
  genvar gi;
  generate
    for (gi = 1; gi < cdr_pkg::NUM_SLOTS; gi++)
    begin : g_slot
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          reg_r[gi] <= cdr_pkg::REG_DEFAULT[gi];
        else if (soft_reset_hit)
          reg_r[gi] <= cdr_pkg::REG_DEFAULT[gi];
        else if (accept && (slot == 3'(gi)))
          reg_r[gi] <= rx_full & cdr_pkg::REG_MASK[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Field unpacking
  // ------------------------------------------------------------
  cdr_pkg::cdr_config_type cfg;
  logic [31:0] g_w;
  logic [31:0] d_w;
  logic [31:0] v_w;
  logic [31:0] p_w;

  assign g_w = reg_r[0];
  assign d_w = reg_r[3];
  assign v_w = reg_r[cdr_pkg::SLOT_DIVIDER];
  assign p_w = reg_r[cdr_pkg::SLOT_PROTECT];

  always_comb
  begin
    cfg = '0;
    cfg.power_down = g_w[cdr_pkg::POWER_DOWN_BIT];
    cfg.group_sleep_bit = g_w[cdr_pkg::GROUP_SLEEP_LSB +: 4];
    cfg.in_buf_type = g_w[cdr_pkg::IN_BUF_LSB +: 2];
    cfg.in0_div = g_w[cdr_pkg::IN0_DIV_LSB +: 3];
    cfg.in0_mux = g_w[cdr_pkg::IN0_MUX_LSB +: 2];
    cfg.in1_div = g_w[cdr_pkg::IN1_DIV_LSB +: 3];
    cfg.in1_mux = g_w[cdr_pkg::IN1_MUX_LSB +: 2];
    cfg.analog_delay_value = d_w[cdr_pkg::ADLY_LSB +: 6];
    cfg.half_shift_bit = d_w[cdr_pkg::HALF_SHIFT_BIT];
    cfg.sync_qualify_field = d_w[cdr_pkg::QUAL_LSB +: 2];
    cfg.sync_in0_polarity = d_w[cdr_pkg::POL0_BIT];
    cfg.sync_in1_polarity = d_w[cdr_pkg::POL1_BIT];
    cfg.exclude_group_a_low = d_w[cdr_pkg::EXCLUDE_LSB];
    cfg.exclude_group_a_high = d_w[cdr_pkg::EXCLUDE_LSB + 1];
    cfg.exclude_group_b_main = d_w[cdr_pkg::EXCLUDE_LSB + 2];
    cfg.exclude_group_b_delayed = d_w[cdr_pkg::EXCLUDE_LSB + 3];
    cfg.offset_off_group_a_low = d_w[cdr_pkg::OFFSET_LSB];
    cfg.offset_off_group_a_high = d_w[cdr_pkg::OFFSET_LSB + 1];
    cfg.offset_off_group_b_main = d_w[cdr_pkg::OFFSET_LSB + 2];
    cfg.sync_in0_fast_enable = d_w[cdr_pkg::FAST_LSB];
    cfg.sync_in1_fast_enable = d_w[cdr_pkg::FAST_LSB + 1];
    cfg.sync_in0_auto_trigger = d_w[cdr_pkg::AUTO0_BIT];
    cfg.sync_in1_auto_trigger = d_w[cdr_pkg::AUTO1_BIT];
    cfg.digital_delay_count = reg_r[cdr_pkg::SLOT_DDLY][cdr_pkg::DDLY_LSB +: 10];
    cfg.divider_group_a_low = v_w[cdr_pkg::DIV_A_LOW_LSB +: 3];
    cfg.divider_group_a_high = v_w[cdr_pkg::DIV_A_HIGH_LSB +: 3];
    cfg.divider_group_b_main = v_w[cdr_pkg::DIV_B_MAIN_LSB +: 3];
    cfg.delay_select_out12 = v_w[cdr_pkg::SEL12_BIT];
    cfg.delay_select_out13 = v_w[cdr_pkg::SEL13_BIT];
    cfg.divider_group_b_delayed = v_w[cdr_pkg::DIV_B_DLY_LSB +: 11];
    cfg.register_write_lock = p_w[cdr_pkg::LOCK_BIT];
  end

  assign CFG = cfg;

  // ------------------------------------------------------------
  // Output format fields
  // ------------------------------------------------------------
  // First four fields are only three bits wide; top bit reads zero
  genvar fi;
  generate
    for (fi = 0; fi < 14; fi++)
    begin : g_fmt
      if (fi < 4)
      begin : g_narrow
        assign OUTPUT_FORMAT_FIELD[fi] =
          {1'b0, reg_r[1][cdr_pkg::FMT3_LSB + cdr_pkg::FMT3_W * fi +: 3]};
      end
      else if (fi < 8)
      begin : g_wide_low
        assign OUTPUT_FORMAT_FIELD[fi] =
          reg_r[1][cdr_pkg::FMT4_LOW_LSB + cdr_pkg::FMT4_W * (fi - 4) +: 4];
      end
      else
      begin : g_wide_high
        assign OUTPUT_FORMAT_FIELD[fi] =
          reg_r[2][cdr_pkg::FMT4_HIGH_LSB + cdr_pkg::FMT4_W * (fi - 8) +: 4];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Power control
  // ------------------------------------------------------------
  assign DEVICE_POWER_DOWN = cfg.power_down;
  assign GROUP_ACTIVE = ~cfg.group_sleep_bit & {4{~cfg.power_down}};
  // Delay block is unpowered unless one of its two outputs uses it
  assign ANALOG_DELAY_ACTIVE = (cfg.delay_select_out12 || cfg.delay_select_out13)
    && GROUP_ACTIVE[3];

  // ------------------------------------------------------------
  // Automatic sync triggers
  // ------------------------------------------------------------
  logic sync0_r;
  logic sync1_r;
  logic [3:0] sync_groups_r;
  logic [3:0] exclude;

  assign exclude = {cfg.exclude_group_b_delayed, cfg.exclude_group_b_main,
    cfg.exclude_group_a_high, cfg.exclude_group_a_low};

  // Auto bits sampled before the write; delay/divider writes never alter them
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync0_r <= 1'b0;
      sync1_r <= 1'b0;
    end
    else
    begin
      sync0_r <= accept && !soft_reset_hit && (slot == cdr_pkg::SLOT_DIVIDER)
        && cfg.sync_in0_auto_trigger;
      sync1_r <= accept && !soft_reset_hit
        && ((slot == cdr_pkg::SLOT_DDLY) || (slot == cdr_pkg::SLOT_DIVIDER))
        && cfg.sync_in1_auto_trigger;
    end
  end

  // Groups taking part in the sync just started
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      sync_groups_r <= 4'h0;
    else if (accept && ((slot == cdr_pkg::SLOT_DDLY) || (slot == cdr_pkg::SLOT_DIVIDER)))
      sync_groups_r <= ~exclude & GROUP_ACTIVE;
  end

  assign SYNC_START_IN0 = sync0_r;
  assign SYNC_START_IN1 = sync1_r;
  assign SYNC_GROUPS = sync_groups_r;

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  logic reject_r;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      reject_r <= 1'b0;
    else
      reject_r <= rx_valid && slot_hit && lock_blocks;
  end

  assign SOFT_RESET_FLAG = g_w[cdr_pkg::SOFT_RESET_BIT];
  assign WRITE_LOCKED = cfg.register_write_lock;
  assign WRITE_REJECTED = reject_r;

endmodule // cdr_regbank

//--- verif/cdr_host_model.sv
`timescale 1ns/10ps
module cdr_host_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  // Shift clock stands still low between words
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end

  // ------------------------------------------------------------
  // One word: address nibble low, MSB first, then strobe
  // ------------------------------------------------------------
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    for (int i = 31; i >= 0; i--)
    begin
      ser_clk <= 1'b0;
      ser_data <= w[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    ser_clk <= 1'b0;
    repeat (4) @(posedge clk);
    ser_le <= 1'b1;
    // Stale data line flips so a late sample shows up
    ser_data <= ~w[0];
    repeat (4) @(posedge clk);
    ser_le <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule // cdr_host_model

//--- verif/cdr_regbank_monitor.sv
`timescale 1ns/10ps
module cdr_regbank_monitor (
  input logic CLK,
  input logic RST_N,
  input cdr_pkg::cdr_config_type CFG,
  input logic [3:0] GROUP_ACTIVE,
  input logic DEVICE_POWER_DOWN,
  input logic ANALOG_DELAY_ACTIVE,
  input logic SYNC_START_IN0,
  input logic SYNC_START_IN1,
  input logic [3:0] SYNC_GROUPS,
  input logic SOFT_RESET_FLAG,
  input logic WRITE_LOCKED,
  input logic WRITE_REJECTED
);
  logic [3:0] excl;
  assign excl = {CFG.exclude_group_b_delayed, CFG.exclude_group_b_main,
    CFG.exclude_group_a_high, CFG.exclude_group_a_low};
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_soft_defaults: assert property ($rose(SOFT_RESET_FLAG) |->
    CFG.digital_delay_count == 10'h005 && !CFG.power_down && CFG.sync_in1_auto_trigger)
    else $error("soft reset left a field off its default");
  a_power_match: assert property (DEVICE_POWER_DOWN == CFG.power_down)
    else $error("power down output differs from its bit");
  a_group_power: assert property (GROUP_ACTIVE ==
    (~CFG.group_sleep_bit & {4{!DEVICE_POWER_DOWN}}))
    else $error("group power state wrong");
  a_sync_in0_auto_trigger: assert property (SYNC_START_IN0 |-> CFG.sync_in0_auto_trigger)
    else $error("sync 0 started without its auto bit");
  a_sync_pair: assert property (SYNC_START_IN0 && CFG.sync_in1_auto_trigger |->
    SYNC_START_IN1)
    else $error("divider write started sync 0 but not sync 1");
  a_sync_pulse: assert property (SYNC_START_IN1 |=> !SYNC_START_IN1)
    else $error("sync 1 start longer than one cycle");
  a_sync_groups: assert property (SYNC_START_IN1 |->
    SYNC_GROUPS == (~excl & GROUP_ACTIVE))
    else $error("synchronised groups ignore exclusion");
  a_lock_hold: assert property ($past(WRITE_LOCKED) && WRITE_LOCKED |->
    $stable(CFG.digital_delay_count) && $stable(CFG.divider_group_b_delayed))
    else $error("locked register changed");
  a_reject_lock: assert property (WRITE_REJECTED |-> WRITE_LOCKED && !SYNC_START_IN1)
    else $error("write refused while unlocked");
  a_adly_power: assert property (ANALOG_DELAY_ACTIVE ==
    ((CFG.delay_select_out12 | CFG.delay_select_out13) & GROUP_ACTIVE[3]))
    else $error("analog delay power state wrong");
  a_power_keeps: assert property ($changed(DEVICE_POWER_DOWN) && !SOFT_RESET_FLAG |->
    $stable(CFG.digital_delay_count) && $stable(CFG.analog_delay_value)
    && $stable(CFG.divider_group_b_delayed))
    else $error("power down changed another setting");
endmodule // cdr_regbank_monitor

bind cdr_regbank cdr_regbank_monitor u_cdr_regbank_monitor (.CLK, .RST_N, .CFG,
  .GROUP_ACTIVE, .DEVICE_POWER_DOWN, .ANALOG_DELAY_ACTIVE, .SYNC_START_IN0,
  .SYNC_START_IN1, .SYNC_GROUPS, .SOFT_RESET_FLAG, .WRITE_LOCKED, .WRITE_REJECTED);

//--- verif/tb.sv
`timescale 1ns/10ps
module tb;
  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SERIAL_CLOCK, SERIAL_DATA, LATCH_ENABLE_STROBE;
  cdr_pkg::cdr_config_type CFG;
  logic [13:0][3:0] OUTPUT_FORMAT_FIELD;
  logic [3:0] GROUP_ACTIVE, SYNC_GROUPS, excl;
  logic [2:0] offs;
  logic DEVICE_POWER_DOWN, ANALOG_DELAY_ACTIVE, SYNC_START_IN0, SYNC_START_IN1;
  logic SOFT_RESET_FLAG, WRITE_LOCKED, WRITE_REJECTED;
  int bad_count = 0;
  int compares = 0;
  int n_in0 = 0;
  int n_in1 = 0;
  int n_rej = 0;
  logic [31:0] div_word;

  always #5 CLK = ~CLK;
  assign excl = {CFG.exclude_group_b_delayed, CFG.exclude_group_b_main,
    CFG.exclude_group_a_high, CFG.exclude_group_a_low};
  assign offs = {CFG.offset_off_group_b_main, CFG.offset_off_group_a_high,
    CFG.offset_off_group_a_low};
  assign div_word = {4'h0, 11'h40D, 2'h0, 1'b0, 1'b1, 3'h7, 3'h5, 3'h3, 4'h5};

  // Pulses are counted, so checks need no exact cycle
  always @(posedge CLK)
  begin
    if (SYNC_START_IN0 === 1'b1) n_in0++;
    if (SYNC_START_IN1 === 1'b1) n_in1++;
    if (WRITE_REJECTED === 1'b1) n_rej++;
  end

  cdr_regbank u_cdr_regbank (.CLK, .RST_N, .SERIAL_CLOCK, .SERIAL_DATA,
    .LATCH_ENABLE_STROBE, .CFG, .OUTPUT_FORMAT_FIELD, .GROUP_ACTIVE, .DEVICE_POWER_DOWN,
    .ANALOG_DELAY_ACTIVE, .SYNC_START_IN0, .SYNC_START_IN1, .SYNC_GROUPS,
    .SOFT_RESET_FLAG, .WRITE_LOCKED, .WRITE_REJECTED);
  cdr_host_model u_cdr_host_model (.clk(CLK), .ser_clk(SERIAL_CLOCK),
    .ser_data(SERIAL_DATA), .ser_le(LATCH_ENABLE_STROBE));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] w);
    u_cdr_host_model.send(w);
  endtask

  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_defaults();
    for (int i = 0; i < 14; i++)
      chk(OUTPUT_FORMAT_FIELD[i], 32'h1, "format");
    chk(CFG.analog_delay_value, 32'h0, "adly");
    chk(CFG.half_shift_bit, 32'h0, "half_shift");
    chk(CFG.sync_qualify_field, 32'h0, "qualify");
    chk({CFG.sync_in1_polarity, CFG.sync_in0_polarity}, 32'h3, "polarity");
    chk(excl, 32'h0, "exclude");
    chk(offs, 32'h3, "offset");
    chk({CFG.sync_in1_auto_trigger, CFG.sync_in0_auto_trigger}, 32'h3, "auto");
    chk(CFG.digital_delay_count, 32'h5, "ddly");
    chk({CFG.divider_group_b_main, CFG.divider_group_a_high,
      CFG.divider_group_a_low}, 32'h49, "div3");
    chk({CFG.delay_select_out13, CFG.delay_select_out12}, 32'h0, "sel");
    chk(CFG.divider_group_b_delayed, 32'h1, "div11");
    chk(WRITE_LOCKED, 32'h0, "lock");
    chk(GROUP_ACTIVE, 32'hF, "active");
    chk(DEVICE_POWER_DOWN, 32'h0, "power_down");
    chk(ANALOG_DELAY_ACTIVE, 32'h0, "adly_active");
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk_defaults();
    wr(32'h8765B1A1);
    wr(32'h0ABCDEF2);
    for (int i = 0; i < 4; i++)
      chk(OUTPUT_FORMAT_FIELD[i], i + 2, "fmt_low");
    for (int i = 4; i < 8; i++)
      chk(OUTPUT_FORMAT_FIELD[i], i + 1, "fmt_mid");
    for (int i = 8; i < 14; i++)
      chk(OUTPUT_FORMAT_FIELD[i], 23 - i, "fmt_high");
    // Delay write starts only sync 1
    wr(32'h00002A54);
    chk(n_in0, 32'h0, "sync0_count");
    chk(n_in1, 32'h1, "sync1_count");
    wr(div_word);
    chk(n_in0, 32'h1, "sync0_count");
    chk(n_in1, 32'h2, "sync1_count");
    chk({CFG.divider_group_b_main, CFG.divider_group_a_high,
      CFG.divider_group_a_low}, 32'h1EB, "div3");
    chk({CFG.delay_select_out13, CFG.delay_select_out12}, 32'h1, "sel");
    chk(CFG.divider_group_b_delayed, 32'h40D, "div11");
    chk(SYNC_GROUPS, 32'hF, "sync_groups");
    chk(ANALOG_DELAY_ACTIVE, 32'h1, "adly_active");
    // Control write takes effect with no sync event
    wr({4'h0, 3'h2, 2'h3, 3'h4, 4'h5, 2'h2, 1'b0, 2'h2, 1'b1, 6'h2A, 4'h3});
    chk(CFG.analog_delay_value, 32'h2A, "adly");
    chk(CFG.half_shift_bit, 32'h1, "half_shift");
    chk(CFG.sync_qualify_field, 32'h2, "qualify");
    chk({CFG.sync_in1_polarity, CFG.sync_in0_polarity}, 32'h2, "polarity");
    chk(excl, 32'h5, "exclude");
    chk(offs, 32'h4, "offset");
    chk(n_in1, 32'h2, "sync1_count");
    wr(div_word);
    chk(n_in0, 32'h1, "sync0_count");
    chk(n_in1, 32'h3, "sync1_count");
    chk(SYNC_GROUPS, 32'hA, "sync_groups");
    // Power down keeps the rest
    wr(32'h00000060);
    chk(DEVICE_POWER_DOWN, 32'h1, "power_down");
    chk(GROUP_ACTIVE, 32'h0, "active");
    chk(ANALOG_DELAY_ACTIVE, 32'h0, "adly_active");
    chk(CFG.digital_delay_count, 32'h2A5, "ddly");
    chk(CFG.analog_delay_value, 32'h2A, "adly");
    chk(SOFT_RESET_FLAG, 32'h0, "soft_flag");
    wr(32'h00000040);
    chk(DEVICE_POWER_DOWN, 32'h0, "power_down");
    chk(GROUP_ACTIVE, 32'hE, "active");
    chk(ANALOG_DELAY_ACTIVE, 32'h1, "adly_active");
    // Locked bank refuses writes
    wr(32'h0000001F);
    chk(WRITE_LOCKED, 32'h1, "lock");
    wr(32'h00001114);
    chk(CFG.digital_delay_count, 32'h2A5, "ddly");
    chk(n_rej, 32'h1, "reject_count");
    chk(n_in1, 32'h3, "sync1_count");
    wr(32'h0000000F);
    chk(WRITE_LOCKED, 32'h0, "lock");
    // Soft reset with junk in the rest of the word
    wr(32'h00FFFFF0);
    chk_defaults();
    chk(SOFT_RESET_FLAG, 32'h1, "soft_flag");
    chk(n_in0, 32'h1, "sync0_count");
    wr(32'h12345677);
    chk(SOFT_RESET_FLAG, 32'h1, "soft_flag");
    chk(CFG.digital_delay_count, 32'h5, "ddly");
    wr(32'h00000504);
    chk(SOFT_RESET_FLAG, 32'h0, "soft_flag");
    chk(CFG.digital_delay_count, 32'h50, "ddly");
    // Mid-run reset brings every field back
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk_defaults();
    chk(SYNC_GROUPS, 32'h0, "sync_groups");
    chk(SOFT_RESET_FLAG, 32'h0, "soft_flag");
    summarize();
  end
endmodule // tb
